//--- design/ccp_clock_defines.svh
// register map, field positions, reset values and timing counts of the clock control block
`ifndef CCP_CLOCK_DEFINES_SVH
`define CCP_CLOCK_DEFINES_SVH

// -------------------------------------------------------------------
// register offsets and reset values
// -------------------------------------------------------------------
`define CCP_MODE_OFS   8'hEB
`define CCP_CTL_OFS    8'hF0
`define CCP_FLAG_OFS   8'hF2
`define CCP_MODE_RST   8'hE0
`define CCP_CTL_RST    8'h00
`define CCP_FLAG_RST   5'h08

// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define CCP_MODE_INPUT_DIVIDE_CONTROL  5
`define CCP_MODE_PRS   4:2
`define CCP_CTL_INTSEL 7
`define CCP_CTL_SRES   3
`define CCP_CTL_AUX    2
`define CCP_CTL_WSEL   1
`define CCP_CTL_LPW    0
`define CCP_FLAG_XTS   4
`define CCP_FLAG_BYP   3
`define CCP_FLAG_PSEL  0
`define CCP_DX_OFF     3'h7

// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define CCP_CLK_NS      100
`define CCP_AUX_LOSS_NS 20000
`define CCP_AUX_LOSS_CYC ((`CCP_AUX_LOSS_NS) / (`CCP_CLK_NS))

`endif

//--- design/ccp_pkg.sv
// types shared by the clock control block
`default_nettype none
package ccp_pkg;
    // system clock source
    typedef enum logic [1:0] {
        CCP_SRC_PLL   = 2'b00,
        CCP_SRC_REF   = 2'b01,
        CCP_SRC_REF16 = 2'b10,
        CCP_SRC_AUX   = 2'b11
    } ccp_src_t;
endpackage : ccp_pkg
`default_nettype wire

//--- design/ccp_clock_ctrl.sv
// clock source selection, core prescaler and low-power wait control
`timescale 1ns/1ps
`default_nettype none
`include "ccp_clock_defines.svh"

module ccp_clock_ctrl #(
    parameter int AUX_LOSS_CYC = `CCP_AUX_LOSS_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // clock sources, sampled as levels
    input  wire logic             raw_oscillator_clock,
    input  wire logic             pll_clock_in,
    input  wire logic             auxiliary_clock_input,
    // pll status and settings from the pll configuration
    input  wire logic             pll_lock,
    input  wire logic             pll_free_run_enable,
    input  wire logic [2:0]       pll_divider_code,
    // core events
    input  wire logic             wfi_enter,
    input  wire logic             wfi_wake,
    input  wire logic             halt_exec,
    input  wire logic             mem_wait,
    input  wire logic             bus_request,
    input  wire logic             hw_stop_restart,
    input  wire logic             ext_int_in,
    // clocks and controls out
    output logic                  system_clock,
    output logic                  peripheral_clock,
    output logic                  core_clock,
    output ccp_pkg::ccp_src_t     active_source,
    output logic                  pll_enable,
    output logic                  crystal_enable,
    output logic                  clock_event_interrupt_channel,
    output logic                  soft_reset_req,
    output logic                  unit_off
);
    import ccp_pkg::*;

    // flag reset image held as a sized constant so its bits can be selected
    localparam logic [4:0] FLAG_RST = `CCP_FLAG_RST;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic [7:0]  mode_reg;
    logic [7:0]  ctl_reg;
    logic        crystal_stop_enable;
    logic        divide16_bypass;
    logic        pll_clock_select;
    logic        raw_d;
    logic        ref_half;
    logic        ref_d;
    logic [3:0]  ref_cnt;
    logic        aux_s1;
    logic        aux_s2;
    logic        aux_s3;
    logic [11:0] aux_cnt;
    logic        aux_present;
    logic        wfi_state;
    logic [2:0]  pcnt;
    logic [2:0]  prs_cur;
    logic        slow_d;
    logic        lock_d;
    ccp_src_t    next_sel;

    logic        reference_clock;
    logic        ref16;
    logic        auxiliary_active_status;
    logic        wfi_lp;
    logic        sys_lvl;
    logic        sys_rise;
    logic        hold_core;
    logic        clk_event;
    logic        wr_mode;
    logic        wr_ctl;
    logic        wr_flag;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    // level of a given source; used for the live source and the candidate
    function automatic logic src_level(input ccp_src_t s, input logic pll_v,
                                       input logic ref_v, input logic r16_v,
                                       input logic aux_v);
        case (s)
            CCP_SRC_PLL:   src_level = pll_v;
            CCP_SRC_REF:   src_level = ref_v;
            CCP_SRC_REF16: src_level = r16_v;
            default:       src_level = aux_v;
        endcase
    endfunction : src_level

    assign wr_mode = reg_wr && (reg_addr == `CCP_MODE_OFS);
    assign wr_ctl  = reg_wr && (reg_addr == `CCP_CTL_OFS);
    assign wr_flag = reg_wr && (reg_addr == `CCP_FLAG_OFS);

    // -------------------------------------------------------------------
    // reference clock and divide-by-16
    // -------------------------------------------------------------------
    // halve the raw oscillator by toggling on its rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            raw_d    <= 1'b0;
            ref_half <= 1'b0;
        end else begin
            raw_d <= raw_oscillator_clock;
            if (raw_oscillator_clock && !raw_d) begin
                ref_half <= !ref_half;
            end
        end
    end

    // input divide bit picks halved or raw oscillator
    assign reference_clock = mode_reg[`CCP_MODE_INPUT_DIVIDE_CONTROL] ? ref_half : raw_oscillator_clock;

    // sixteen reference edges make one reference/16 period
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_d   <= 1'b0;
            ref_cnt <= 4'h0;
        end else begin
            ref_d <= reference_clock;
            if (reference_clock && !ref_d) begin
                ref_cnt <= ref_cnt + 4'h1;
            end
        end
    end
    assign ref16 = ref_cnt[3];

    // -------------------------------------------------------------------
    // auxiliary presence detector
    // -------------------------------------------------------------------
    // two-stage synchroniser, edge seen between second and third stage
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_s1      <= 1'b0;
            aux_s2      <= 1'b0;
            aux_s3      <= 1'b0;
            aux_cnt     <= 12'hFFF;
            aux_present <= 1'b0;
        end else begin
            aux_s1 <= auxiliary_clock_input;
            aux_s2 <= aux_s1;
            aux_s3 <= aux_s2;
            if (aux_s2 != aux_s3) begin
                aux_cnt <= 12'h000;
            end else if (aux_cnt != 12'hFFF) begin
                aux_cnt <= aux_cnt + 12'h001;
            end
            aux_present <= (aux_cnt < 12'(AUX_LOSS_CYC));
        end
    end

    // selection only counts while a clock is really there
    assign auxiliary_active_status = aux_present && ctl_reg[`CCP_CTL_AUX];

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    // mode register: input divide and core prescale
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= `CCP_MODE_RST;
        end else if (wr_mode) begin
            mode_reg <= reg_wdata;
        end
    end

    // clock control; low-power wait entry with a present aux wait clock sets the aux select bit
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_reg <= `CCP_CTL_RST;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= reg_wdata;
            end
            if (wfi_enter && ctl_reg[`CCP_CTL_LPW] && ctl_reg[`CCP_CTL_WSEL]
                && aux_present) begin
                ctl_reg[`CCP_CTL_AUX] <= 1'b1;
            end
        end
    end

    // flag bits; hardware clears of the pll select beat a software set,
    // so a pll with divider code off and no free run can never be picked in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            crystal_stop_enable <= FLAG_RST[`CCP_FLAG_XTS];
            divide16_bypass     <= FLAG_RST[`CCP_FLAG_BYP];
            pll_clock_select    <= FLAG_RST[`CCP_FLAG_PSEL];
        end else begin
            if (wr_flag) begin
                crystal_stop_enable <= reg_wdata[`CCP_FLAG_XTS];
                divide16_bypass     <= reg_wdata[`CCP_FLAG_BYP];
                pll_clock_select    <= reg_wdata[`CCP_FLAG_PSEL];
            end
            if ((wfi_enter && ctl_reg[`CCP_CTL_LPW])
                || !divide16_bypass || unit_off
                || (crystal_stop_enable && auxiliary_active_status)
                || (pll_divider_code == `CCP_DX_OFF && !pll_free_run_enable)) begin
                pll_clock_select <= 1'b0;
            end
        end
    end

    // read data; stop enable reads low until the aux clock is active
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCP_MODE_OFS: reg_rdata <= mode_reg;
                `CCP_CTL_OFS:  reg_rdata <= ctl_reg;
                `CCP_FLAG_OFS: reg_rdata <= {3'h0,
                                   crystal_stop_enable && auxiliary_active_status,
                                   divide16_bypass, auxiliary_active_status,
                                   pll_lock, pll_clock_select};
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // wait, halt and source choice
    // -------------------------------------------------------------------
    // wait state lasts from the instruction until the wake interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            wfi_state <= 1'b0;
        end else if (wfi_enter) begin
            wfi_state <= 1'b1;
        end else if (wfi_wake) begin
            wfi_state <= 1'b0;
        end
    end
    assign wfi_lp = wfi_state && ctl_reg[`CCP_CTL_LPW];

    // aux overrides all; low power and cleared bypass force ref/16
    always_comb begin
        if (auxiliary_active_status) begin
            next_sel = CCP_SRC_AUX;
        end else if (wfi_lp || !divide16_bypass) begin
            next_sel = CCP_SRC_REF16;
        end else if (pll_clock_select && (pll_lock || pll_free_run_enable)) begin
            next_sel = CCP_SRC_PLL;
        end else begin
            next_sel = CCP_SRC_REF;
        end
    end

    // halt either asks for reset or shuts the unit until reset
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_reset_req <= 1'b0;
            unit_off       <= 1'b0;
        end else begin
            soft_reset_req <= halt_exec && ctl_reg[`CCP_CTL_SRES];
            if (halt_exec && !ctl_reg[`CCP_CTL_SRES]) begin
                unit_off <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // system clock
    // -------------------------------------------------------------------
    assign sys_lvl  = src_level(active_source, pll_clock_in, reference_clock,
                                ref16, aux_s2);
    assign sys_rise = sys_lvl && !system_clock;

    // switch only while both old and new clocks sit low, so no runt appears;
    // a stuck-high new source delays the switch until it drops
    always_ff @(posedge clk) begin
        if (rst) begin
            active_source <= CCP_SRC_REF;
        end else if (next_sel != active_source && !system_clock && !sys_lvl
                     && !src_level(next_sel, pll_clock_in, reference_clock,
                                   ref16, aux_s2)) begin
            active_source <= next_sel;
        end
    end

    // peripherals take the same undivided clock as the prescaler input
    always_ff @(posedge clk) begin
        if (rst) begin
            system_clock     <= 1'b0;
            peripheral_clock <= 1'b0;
        end else begin
            system_clock     <= sys_lvl && !unit_off;
            peripheral_clock <= sys_lvl && !unit_off;
        end
    end

    // -------------------------------------------------------------------
    // core clock prescaler
    // -------------------------------------------------------------------
    // wait, halt without reset enable and bus stretch all freeze the core clock high
    assign hold_core = mem_wait || bus_request || wfi_state || unit_off;

    // count system rising edges; new ratio loads only at period end
    always_ff @(posedge clk) begin
        if (rst) begin
            pcnt    <= 3'h0;
            prs_cur <= 3'h0;
        end else if (!hold_core && sys_rise) begin
            if (pcnt == prs_cur) begin
                pcnt    <= 3'h0;
                prs_cur <= mode_reg[`CCP_MODE_PRS];
            end else begin
                pcnt <= pcnt + 3'h1;
            end
        end
    end

    // low only in the last system cycle's low half; zero ratio follows it
    always_ff @(posedge clk) begin
        if (rst) begin
            core_clock <= 1'b0;
        end else if (hold_core) begin
            core_clock <= 1'b1;
        end else begin
            core_clock <= (pcnt == prs_cur) ? sys_lvl : 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // oscillator and pll enables
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            crystal_enable <= 1'b1;
            pll_enable     <= 1'b0;
        end else begin
            crystal_enable <= !unit_off && !(crystal_stop_enable
                                             && auxiliary_active_status);
            pll_enable     <= !unit_off && divide16_bypass
                              && (pll_divider_code != `CCP_DX_OFF || pll_free_run_enable)
                              && !(wfi_lp && !pll_free_run_enable);
        end
    end

    // -------------------------------------------------------------------
    // clock event interrupt
    // -------------------------------------------------------------------
    assign clk_event = ((active_source == CCP_SRC_AUX
                         || active_source == CCP_SRC_REF16) != slow_d)
                       || (pll_lock != lock_d) || hw_stop_restart;

    always_ff @(posedge clk) begin
        if (rst) begin
            slow_d <= 1'b0;
            lock_d <= 1'b0;
            clock_event_interrupt_channel <= 1'b1;
        end else begin
            slow_d <= (active_source == CCP_SRC_AUX || active_source == CCP_SRC_REF16);
            lock_d <= pll_lock;
            // one low cycle gives the falling edge the channel expects
            clock_event_interrupt_channel <= ctl_reg[`CCP_CTL_INTSEL]
                                             ? !clk_event : ext_int_in;
        end
    end

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    core_follow_a: assert property (@(posedge clk) disable iff (rst)
        (prs_cur == 3'h0 && !hold_core) |=> (core_clock == system_clock || unit_off))
        else $error("undivided core clock differs from system clock");
    core_hold_a: assert property (@(posedge clk) disable iff (rst)
        (mem_wait || bus_request) |=> core_clock)
        else $error("core clock not held high during stretch");
    periph_clock_a: assert property (@(posedge clk) disable iff (rst)
        peripheral_clock == system_clock)
        else $error("peripheral clock differs from system clock");
    aux_present_a: assert property (@(posedge clk) disable iff (rst)
        next_sel == CCP_SRC_AUX |-> aux_present)
        else $error("absent auxiliary clock chosen");
    lp_source_a: assert property (@(posedge clk) disable iff (rst)
        (wfi_lp && !auxiliary_active_status) |-> next_sel == CCP_SRC_REF16)
        else $error("low power wait not on reference/16");
    pll_off_a: assert property (@(posedge clk) disable iff (rst)
        (wfi_lp && !pll_free_run_enable) |=> !pll_enable)
        else $error("pll left running in low power wait");
    psel_clear_a: assert property (@(posedge clk) disable iff (rst)
        (wfi_enter && ctl_reg[`CCP_CTL_LPW]) |=> !pll_clock_select)
        else $error("pll select survived low power wait entry");
    xtal_stop_a: assert property (@(posedge clk) disable iff (rst)
        (crystal_stop_enable && auxiliary_active_status) |=> !crystal_enable)
        else $error("crystal running with stop enabled on aux");
    event_fall_a: assert property (@(posedge clk) disable iff (rst)
        (clk_event && ctl_reg[`CCP_CTL_INTSEL]) |=> !clock_event_interrupt_channel)
        else $error("clock event produced no low level");
    halt_reset_a: assert property (@(posedge clk) disable iff (rst)
        (halt_exec && ctl_reg[`CCP_CTL_SRES]) |=> soft_reset_req ##1 !unit_off)
        else $error("halt with reset enable misbehaved");
    reset_state_a: assert property (@(posedge clk)
        rst |=> (mode_reg == `CCP_MODE_RST && ctl_reg == `CCP_CTL_RST && divide16_bypass))
        else $error("reset values wrong");
endmodule : ccp_clock_ctrl
`default_nettype wire

//--- testbench/cpu_clock_prescale_lowpower_tb_top.sv
// self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_prescale_lowpower_tb_top;
    import ccp_pkg::*;
    // -------------------------------------------------------------------
    // stimulus and observed signals
    // -------------------------------------------------------------------
    logic       clk, rst, reg_wr, reg_rd, raw_oscillator_clock, pll_clock_in, wfi_enter;
    logic       wfi_wake, halt_exec, mem_wait, bus_request, hw_stop_restart, ext_int_in;
    logic       system_clock, peripheral_clock, core_clock, pll_enable, crystal_enable;
    logic       clock_event_interrupt_channel, soft_reset_req, unit_off, ext_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    ccp_src_t   active_source;
    int         err_total, samples_checked, cycles, seed, n, c;
    // -------------------------------------------------------------------
    // design under test, pll status tied idle
    // -------------------------------------------------------------------
    ccp_clock_ctrl #(.AUX_LOSS_CYC(8)) uut (.*, .pll_lock(1'b0), .pll_free_run_enable(1'b0),
        .pll_divider_code(3'h7), .auxiliary_clock_input(1'b0));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard: the sequence needs well under 5000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end
    // free-running sources and random channel input, driven off the sampling edge
    always @(negedge clk) begin
        chk("periph", 8'(peripheral_clock), 8'(system_clock));
        if (ext_on) chk("channel", 8'(clock_event_interrupt_channel), 8'(ext_int_in));
        raw_oscillator_clock = ~raw_oscillator_clock;
        ext_int_in = 1'($random(seed));
        pll_clock_in = 1'($random(seed));
    end
    // -------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(nm, reg_rdata, exp);
    endtask : rd
    // one-cycle pulse: 0 wait entry, 1 wake, 2 halt, 3 restart
    task automatic pulse(input int w);
        @(negedge clk);
        {wfi_enter, wfi_wake, halt_exec, hw_stop_restart} = 4'b1000 >> w;
        @(negedge clk);
        {wfi_enter, wfi_wake, halt_exec, hw_stop_restart} = 4'b0000;
    endtask : pulse
    // count low samples of the channel (or high samples of soft reset) over k cycles
    task automatic lows(input int k, input bit sr, output int cnt);
        cnt = 0;
        // first sample in the cycle right after the pulse, where the answer stands
        repeat (k) begin
            cnt += sr ? int'(soft_reset_req) : int'(!clock_event_interrupt_channel);
            @(negedge clk);
        end
    endtask : lows
    // one core period: clk cycles, system rises, low-phase and same-phase flags
    task automatic measure(input int p, output int cyc, output int ns);
        logic ps, pc, bad, dif;
        int ph;
        ps = system_clock;
        pc = core_clock;
        {bad, dif, ph, cyc, ns} = '0;
        for (int k = 0; k < 200 && ph < 2; k++) begin
            @(negedge clk);
            if (ph == 1) cyc++;
            if (ph == 1 && system_clock && !ps) ns++;
            if (core_clock && !pc) ph++;
            bad |= !core_clock && system_clock;
            dif |= core_clock !== system_clock;
            {ps, pc} = {system_clock, core_clock};
        end
        chk("low phase", 8'(bad), 8'h00);
        if (p == 0) chk("same phase", 8'(dif), 8'h00);
    endtask : measure
    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        {err_total, samples_checked, cycles, ext_on, raw_oscillator_clock} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, mem_wait, bus_request} = '0;
        {wfi_enter, wfi_wake, halt_exec, hw_stop_restart, ext_int_in, pll_clock_in} = '0;
        seed = 32'h772B;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        rd(8'hEB, 8'hE0, "mode");
        rd(8'hF0, 8'h00, "control");
        rd(8'hF2, 8'h08, "flags");
        rd(8'h55, 8'h00, "unmapped");
        chk("source", 8'(active_source), 8'(CCP_SRC_REF));
        ext_on = 1'b1;
        repeat (24) @(negedge clk);
        ext_on = 1'b0;
        // every ratio, reference period four clk cycles with halving on
        for (int p = 0; p < 8; p++) begin
            wr(8'hEB, {3'b111, p[2:0], 2'b00});
            repeat (40) @(negedge clk);
            measure(p, c, n);
            chk("ratio", 8'(n), 8'(p + 1));
            chk("period", 8'(c), 8'(4 * (p + 1)));
        end
        wr(8'hEB, 8'hC0);
        repeat (20) @(negedge clk);
        measure(0, c, n);
        chk("no halving", 8'(c), 8'h02);
        wr(8'hEB, 8'hE0);
        // memory wait then bus request hold the core clock high
        for (int i = 0; i < 2; i++) begin
            {mem_wait, bus_request} = i ? 2'b01 : 2'b10;
            repeat (6) @(negedge clk);
            repeat (8) begin
                @(negedge clk);
                chk("held", 8'(core_clock), 8'h01);
            end
            {mem_wait, bus_request} = 2'b00;
        end
        pulse(0);
        repeat (6) @(negedge clk);
        chk("wait core", 8'(core_clock), 8'h01);
        chk("wait source", 8'(active_source), 8'(CCP_SRC_REF));
        pulse(1);
        // internal events routed: restart, low-power entry and exit
        wr(8'hF0, 8'h81);
        pulse(3);
        lows(4, 1'b0, n);
        chk("restart event", 8'(n), 8'h01);
        pulse(0);
        // the switch waits for reference/16 to sit low, up to half its period
        lows(70, 1'b0, n);
        chk("entry event", 8'(n), 8'h01);
        chk("slow source", 8'(active_source), 8'(CCP_SRC_REF16));
        chk("pll off", 8'(pll_enable), 8'h00);
        rd(8'hF2, 8'h08, "pll select");
        pulse(1);
        lows(70, 1'b0, n);
        chk("exit event", 8'(n), 8'h01);
        wr(8'hF0, 8'h04);
        repeat (12) @(negedge clk);
        chk("absent aux", 8'(active_source == CCP_SRC_AUX), 8'h00);
        wr(8'hF0, 8'h08);
        pulse(2);
        lows(3, 1'b1, n);
        chk("soft reset", 8'(n), 8'h01);
        wr(8'hF0, 8'h00);
        pulse(2);
        repeat (4) @(negedge clk);
        chk("unit off", 8'({unit_off, system_clock}), 8'h02);
        test_done();
    end
endmodule : cpu_clock_prescale_lowpower_tb_top
`default_nettype wire
